// *** logic/clock_output_pkg.sv ***
// Package with register map, field layout and reset values of the block.
// Overview of operation
// - One four-bit pre-emphasis value drives all eight serial lanes together.
// - Trigger enable bit 7 low stops buffer and divider; high runs them.
// - Select 0,1,2 give 16,32,64 UI clocks; 3 timestamp; 4-7 reserved.
// - Serializer-derived trigger clocks pause while the serializer re-initializes.
// - Override bit 7 chooses pins or register fields as PLL control source.
// - With override, bits 5:4 set second divider output: off, /1, /2, /4.
// - Second divided output runs only while first divided output runs.
// - With override, bits 3:2 set first divider output: off, /1, /2, /4.
// - Without override, both mode fields are ignored; config pins decide.
// - With override, bit 1 replaces reference-select pin; 1 picks single-ended.
// - With override, bit 0 replaces PLL enable pin; 1 turns PLL on.
// - Trigger control resets to 0x00: disabled, 16 UI clock selected.
package clock_output_pkg;
	// Register offsets on the serial port.
	localparam logic [14:0] bias_addr = 15'h003F;
	localparam logic [14:0] emphasis_addr = 15'h0048;
	localparam logic [14:0] trigger_addr = 15'h0057;
	localparam logic [14:0] override_addr = 15'h0058;
	// Reset values.
	localparam logic [7:0] bias_reset = 8'h4F;
	localparam logic [7:0] emphasis_reset = 8'h00;
	localparam logic [7:0] trigger_reset = 8'h00;
	localparam logic [7:0] override_reset = 8'h00;
	// Field positions.
	localparam int trigger_enable_bit = 7;
	localparam int override_enable_bit = 7;
	localparam int refsel_value_bit = 1;
	localparam int pll_enable_value_bit = 0;
	localparam int second_mode_lsb = 4;
	localparam int first_mode_lsb = 2;
	// Serial frame: one read flag, fifteen address bits, eight data bits.
	localparam logic [4:0] header_bits = 5'h10;
	localparam logic [4:0] frame_bits = 5'h18;
	// Trigger select codes.
	localparam logic [2:0] sel_ui16 = 3'h0;
	localparam logic [2:0] sel_ui32 = 3'h1;
	localparam logic [2:0] sel_ui64 = 3'h2;
	localparam logic [2:0] sel_stamp = 3'h3;
	// Half periods of the UI clocks, counted in unit-interval ticks.
	localparam logic [5:0] half_ui16 = 6'h08;
	localparam logic [5:0] half_ui32 = 6'h10;
	localparam logic [5:0] half_ui64 = 6'h20;
	// Divided reference modes.
	localparam logic [1:0] refdiv_off = 2'h0;
	localparam logic [1:0] refdiv_by1 = 2'h1;
	localparam logic [1:0] refdiv_by2 = 2'h2;
	localparam logic [1:0] refdiv_by4 = 2'h3;
endpackage : clock_output_pkg

// *** logic/ref_divider.sv ***
// Divider that makes one divided reference output from the sampled reference.
module ref_divider (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// Reference level and mode.
	input wire logic ref_level,
	input wire logic [1:0] mode,
	// Divided output.
	output logic div_out
);
	logic ref_prev_q;
	logic div2_q;
	logic [1:0] div4_q;
	logic rise;

	assign rise = ref_level & ~ref_prev_q;

	// Edge detector on the sampled reference level.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ref_prev_q <= 1'b0;
		end else begin
			ref_prev_q <= ref_level;
		end
	end

	// Toggle stages; they keep running so a mode change lands mid-phase.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div2_q <= 1'b0;
			div4_q <= 2'h0;
		end else if (rise) begin
			div2_q <= ~div2_q;
			div4_q <= div4_q + 2'h1;
		end
	end

	// Output register selects the stage; off holds the pin low.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div_out <= 1'b0;
		end else begin
			case (mode)
				clock_output_pkg::refdiv_by1: div_out <= ref_level;
				clock_output_pkg::refdiv_by2: div_out <= div2_q;
				clock_output_pkg::refdiv_by4: div_out <= div4_q[1];
				default: div_out <= 1'b0;
			endcase
		end
	end
endmodule : ref_divider

// *** logic/clock_output_config_regs.sv ***
// Serial-port register group for PLL bias, lane emphasis, trigger and overrides.
module clock_output_config_regs #(
	parameter int lane_count = 8
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// Serial register port, sampled on ref_clk.
	input wire logic spi_sclk,
	input wire logic spi_cs_n,
	input wire logic spi_sdi,
	output logic spi_sdo,
	output logic spi_sdo_oe,
	// Configuration pins.
	input wire logic pll_enable_pin,
	input wire logic ref_select_pin,
	input wire logic clock_config_pin_a,
	input wire logic clock_config_pin_b,
	// Reference, lane timing and timestamp.
	input wire logic pll_ref_level,
	input wire logic ui_tick,
	input wire logic serializer_reinit,
	input wire logic timestamp_input,
	// PLL controls.
	output logic [6:0] oscillator_bias_level,
	output logic pll_enable,
	output logic single_ended_ref_select,
	// Lane emphasis, one field per lane.
	output logic [lane_count*4-1:0] lane_emphasis_level,
	// Clock outputs.
	output logic aux_output,
	output logic refdiv_output_a,
	output logic refdiv_output_b
);
	// Stored registers, serial engine state and derived controls.
	logic [7:0] bias_q;
	logic [7:0] emphasis_q;
	logic [7:0] trigger_q;
	logic [7:0] override_q;
	logic sclk_prev_q;
	logic [4:0] count_q;
	logic [23:0] shift_q;
	logic [7:0] out_q;
	logic is_read_q;
	logic sclk_rise;
	logic sclk_fall;
	logic [23:0] shift_d;
	logic [7:0] read_data;
	logic [1:0] first_mode;
	logic [1:0] second_mode;
	logic aux_enable;
	logic [2:0] aux_output_select;
	logic [5:0] half_count;
	logic [5:0] ui_count_q;

	// Edges are judged against the last sample, so sclk must be slow.
	assign sclk_rise = spi_sclk & ~sclk_prev_q & ~spi_cs_n;
	assign sclk_fall = ~spi_sclk & sclk_prev_q & ~spi_cs_n;
	assign shift_d = {shift_q[22:0], spi_sdi};

	// Serial clock edge history.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sclk_prev_q <= 1'b0;
		end else begin
			sclk_prev_q <= spi_sclk;
		end
	end

	// Bit counter and input shifter; chip select high restarts the frame.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			count_q <= 5'h00;
			shift_q <= 24'h000000;
		end else if (spi_cs_n) begin
			count_q <= 5'h00;
		end else if (sclk_rise && count_q != clock_output_pkg::frame_bits) begin
			count_q <= count_q + 5'h01;
			shift_q <= shift_d;
		end
	end

	// Read data selected by the captured address; unmapped reads give zero.
	always_comb begin
		case (shift_q[14:0])
			clock_output_pkg::bias_addr: read_data = bias_q;
			clock_output_pkg::emphasis_addr: read_data = emphasis_q;
			clock_output_pkg::trigger_addr: read_data = trigger_q;
			clock_output_pkg::override_addr: read_data = override_q;
			default: read_data = 8'h00;
		endcase
	end

	// Output shifter loads after the header and moves on falling edges.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			out_q <= 8'h00;
			is_read_q <= 1'b0;
		end else if (spi_cs_n) begin
			is_read_q <= 1'b0;
		end else if (sclk_fall && count_q == clock_output_pkg::header_bits
				&& !is_read_q && shift_q[15]) begin
			is_read_q <= 1'b1;
			out_q <= read_data;
		end else if (sclk_fall && is_read_q) begin
			out_q <= {out_q[6:0], 1'b0};
		end
	end

	// Read data leaves from a flip-flop; driven only during a read body.
	assign spi_sdo = out_q[7];
	assign spi_sdo_oe = is_read_q;

	// Register writes commit on the last data edge of a write frame.
	// Reserved bits are stored as written, since software restores defaults.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			bias_q <= clock_output_pkg::bias_reset;
			emphasis_q <= clock_output_pkg::emphasis_reset;
			trigger_q <= clock_output_pkg::trigger_reset;
			override_q <= clock_output_pkg::override_reset;
		end else if (sclk_rise && !shift_q[22]
				&& count_q == clock_output_pkg::frame_bits - 5'h01) begin
			case (shift_d[22:8])
				clock_output_pkg::bias_addr: bias_q <= shift_d[7:0];
				clock_output_pkg::emphasis_addr: emphasis_q <= shift_d[7:0];
				clock_output_pkg::trigger_addr: trigger_q <= shift_d[7:0];
				clock_output_pkg::override_addr: override_q <= shift_d[7:0];
				default: ;
			endcase
		end
	end

	// Bias goes straight to the oscillator; the PLL reset is software's job.
	// A bias change without that hold may upset a running oscillator.
	assign oscillator_bias_level = bias_q[6:0];

	// One emphasis field copied to every lane at once.
	// Separate per-lane fields could drift apart, so the copy is wired.
	for (genvar lane = 0; lane < lane_count; lane++) begin : g_lane
		assign lane_emphasis_level[lane*4 +: 4] = emphasis_q[3:0];
	end

	// Pin or register control, a plain mux so a write acts at once.
	// In pin mode the stored value fields are ignored entirely.
	always_comb begin
		if (override_q[clock_output_pkg::override_enable_bit]) begin
			pll_enable = override_q[clock_output_pkg::pll_enable_value_bit];
			single_ended_ref_select =
				override_q[clock_output_pkg::refsel_value_bit];
			first_mode = override_q[clock_output_pkg::first_mode_lsb +: 2];
			second_mode =
				override_q[clock_output_pkg::second_mode_lsb +: 2];
		end else begin
			pll_enable = pll_enable_pin;
			single_ended_ref_select = ref_select_pin;
			first_mode = {clock_config_pin_b, clock_config_pin_a};
			second_mode = {clock_config_pin_b, clock_config_pin_a};
		end
	end

	// The first divider output.
	ref_divider u_div_a (
		.ref_clk(ref_clk),
		.rst(rst),
		.ref_level(pll_ref_level),
		.mode(first_mode),
		.div_out(refdiv_output_a)
	);

	// The second output is forced off whenever the first is off.
	ref_divider u_div_b (
		.ref_clk(ref_clk),
		.rst(rst),
		.ref_level(pll_ref_level),
		.mode(first_mode == clock_output_pkg::refdiv_off ?
			clock_output_pkg::refdiv_off : second_mode),
		.div_out(refdiv_output_b)
	);

	// Trigger control fields.
	assign aux_enable = trigger_q[clock_output_pkg::trigger_enable_bit];
	assign aux_output_select = trigger_q[2:0];

	// Half period of the selected UI clock.
	// Reserved codes reuse the slowest count; their output stays low anyway.
	always_comb begin
		case (aux_output_select)
			clock_output_pkg::sel_ui16: half_count = clock_output_pkg::half_ui16;
			clock_output_pkg::sel_ui32: half_count = clock_output_pkg::half_ui32;
			default: half_count = clock_output_pkg::half_ui64;
		endcase
	end

	// UI divider; disabled or a serializer restart holds it, so the clock
	// pauses and restarts from a known phase.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			ui_count_q <= 6'h00;
		end else if (!aux_enable || serializer_reinit) begin
			ui_count_q <= 6'h00;
		end else if (ui_tick) begin
			ui_count_q <= (ui_count_q == half_count - 6'h01) ? 6'h00 :
				ui_count_q + 6'h01;
		end
	end

	// Trigger output: low when disabled or reserved, else clock or timestamp.
	// Holding reserved codes low keeps a bad select from clocking a receiver.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			aux_output <= 1'b0;
		end else if (!aux_enable) begin
			aux_output <= 1'b0;
		end else if (aux_output_select == clock_output_pkg::sel_stamp) begin
			aux_output <= timestamp_input;
		end else if (aux_output_select > clock_output_pkg::sel_stamp) begin
			aux_output <= 1'b0;
		end else if (serializer_reinit) begin
			aux_output <= 1'b0;
		end else if (ui_tick && ui_count_q == half_count - 6'h01) begin
			aux_output <= ~aux_output;
		end
	end
endmodule : clock_output_config_regs

// *** bench/clock_output_monitor.sv ***
// Port checker for the clock output configuration register block.
module clock_output_monitor #(
	parameter int lane_count = 8
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic rst,
	// Causes seen at the inputs.
	input wire logic spi_cs_n,
	input wire logic ui_tick,
	input wire logic serializer_reinit,
	input wire logic timestamp_input,
	input wire logic pll_ref_level,
	input wire logic clock_config_pin_a,
	input wire logic clock_config_pin_b,
	// Watched outputs.
	input wire logic spi_sdo_oe,
	input wire logic [6:0] oscillator_bias_level,
	input wire logic [lane_count*4-1:0] lane_emphasis_level,
	input wire logic aux_output,
	input wire logic refdiv_output_a,
	input wire logic refdiv_output_b
);
	timeunit 1ns;
	timeprecision 100ps;
	// One clock domain, so reset silences every check at once.
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	// A torn update would leave the lanes with unequal settings.
	chk_lane_copy: assert property (
		lane_emphasis_level == {lane_count{lane_emphasis_level[3:0]}})
		else $error("Lane emphasis copies differ.");
	chk_bias_frame: assert property (
		$changed(oscillator_bias_level) |-> !$past(spi_cs_n))
		else $error("Bias changed outside a frame.");
	chk_emph_frame: assert property (
		$changed(lane_emphasis_level) |-> !$past(spi_cs_n))
		else $error("Emphasis changed outside a frame.");
	// Timestamp mode is not serializer-derived and keeps following its input.
	chk_aux_reinit: assert property (
		serializer_reinit |=> !aux_output || $past(timestamp_input))
		else $error("Trigger output ran during re-initialisation.");
	chk_aux_cause: assert property (
		$rose(aux_output) |-> $past(ui_tick) || $past(timestamp_input))
		else $error("Trigger output rose without a cause.");
	// A mode change shows the divider's running phase at once, so a rise
	// right after a write or a pin change needs no reference edge.
	chk_refa_cause: assert property (
		$rose(refdiv_output_a) |-> $past(pll_ref_level) || !$past(spi_cs_n)
			|| $past({clock_config_pin_b, clock_config_pin_a}, 2)
			!= $past({clock_config_pin_b, clock_config_pin_a}))
		else $error("First divided output rose without reference.");
	chk_refb_cause: assert property (
		$rose(refdiv_output_b) |-> $past(pll_ref_level) || !$past(spi_cs_n)
			|| $past({clock_config_pin_b, clock_config_pin_a}, 2)
			!= $past({clock_config_pin_b, clock_config_pin_a}))
		else $error("Second divided output rose without reference.");
	chk_oe_idle: assert property (
		spi_cs_n ##1 spi_cs_n |-> !spi_sdo_oe)
		else $error("Read data driven while deselected.");
endmodule : clock_output_monitor

bind clock_output_config_regs clock_output_monitor #(
	.lane_count(lane_count)
) clock_output_monitor_inst (
	.ref_clk(ref_clk),
	.rst(rst),
	.spi_cs_n(spi_cs_n),
	.ui_tick(ui_tick),
	.serializer_reinit(serializer_reinit),
	.timestamp_input(timestamp_input),
	.pll_ref_level(pll_ref_level),
	.clock_config_pin_a(clock_config_pin_a),
	.clock_config_pin_b(clock_config_pin_b),
	.spi_sdo_oe(spi_sdo_oe),
	.oscillator_bias_level(oscillator_bias_level),
	.lane_emphasis_level(lane_emphasis_level),
	.aux_output(aux_output),
	.refdiv_output_a(refdiv_output_a),
	.refdiv_output_b(refdiv_output_b)
);

// *** bench/test_clock_output_config_regs.sv ***
// Self-checking bench of the clock output configuration registers.
module test_clock_output_config_regs;
	timeunit 1ns;
	timeprecision 100ps;
	logic ref_clk = 0, rst = 1, spi_sclk = 0, spi_cs_n = 1, spi_sdi = 0;
	logic pll_enable_pin = 0, ref_select_pin = 0, clock_config_pin_a = 0;
	logic clock_config_pin_b = 0, pll_ref_level = 0, ui_tick = 0;
	logic serializer_reinit = 0, timestamp_input = 0;
	logic spi_sdo, spi_sdo_oe, pll_enable, single_ended_ref_select;
	logic aux_output, refdiv_output_a, refdiv_output_b;
	logic [6:0] oscillator_bias_level;
	logic [31:0] lane_emphasis_level, p, exp_q[$], got_q[$];
	logic [7:0] rd, d;
	int miscompares = 0, cmp_count = 0, seed = 51;
	wire [2:0] outs = {refdiv_output_b, refdiv_output_a, aux_output};
	clock_output_config_regs clock_output_config_regs_inst (
		.ref_clk(ref_clk),
		.rst(rst),
		.spi_sclk(spi_sclk),
		.spi_cs_n(spi_cs_n),
		.spi_sdi(spi_sdi),
		.spi_sdo(spi_sdo),
		.spi_sdo_oe(spi_sdo_oe),
		.pll_enable_pin(pll_enable_pin),
		.ref_select_pin(ref_select_pin),
		.clock_config_pin_a(clock_config_pin_a),
		.clock_config_pin_b(clock_config_pin_b),
		.pll_ref_level(pll_ref_level),
		.ui_tick(ui_tick),
		.serializer_reinit(serializer_reinit),
		.timestamp_input(timestamp_input),
		.oscillator_bias_level(oscillator_bias_level),
		.pll_enable(pll_enable),
		.single_ended_ref_select(single_ended_ref_select),
		.lane_emphasis_level(lane_emphasis_level),
		.aux_output(aux_output),
		.refdiv_output_a(refdiv_output_a),
		.refdiv_output_b(refdiv_output_b)
	);
	// Clock, a slow reference and a tick on every second cycle.
	always #5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) #1 ui_tick <= ~ui_tick;
	always begin
		repeat (8) @(posedge ref_clk);
		#1 pll_ref_level = ~pll_ref_level;
	end
	// Results are judged apart from the driver, oldest note first.
	always @(negedge ref_clk) while (got_q.size() != 0)
		cmp(exp_q.pop_front(), got_q.pop_front());
	task automatic cmp(input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("FAIL t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : cmp
	task automatic note(input logic [31:0] e, input logic [31:0] g);
		exp_q.push_back(e);
		got_q.push_back(g);
	endtask : note
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	// Each serial level lasts several cycles; read bits sampled when low.
	task automatic frame(input logic [15:0] h, input logic [7:0] v);
		logic [23:0] f;
		f = {h, v};
		spi_cs_n = 0;
		for (int i = 23; i >= 0; i--) begin
			spi_sdi = f[i];
			cyc(3);
			if (i < 8) rd[i] = spi_sdo;
			spi_sclk = 1;
			cyc(2);
			spi_sclk = 0;
		end
		cyc(2);
		spi_cs_n = 1;
		cyc(2);
	endtask : frame
	task automatic wr(input logic [14:0] a, input logic [7:0] v);
		frame({1'b0, a}, v);
	endtask : wr
	task automatic rdck(input logic [14:0] a, input logic [7:0] e);
		frame({1'b1, a}, 8'h00);
		note(32'(e), 32'(rd));
	endtask : rdck
	// Period between two rising edges; zero when the output stays still.
	task automatic per(input int k);
		int a;
		logic o;
		a = -1;
		p = 0;
		// A fresh mode may show one short phase, so let it pass first.
		cyc(2);
		o = outs[k];
		for (int n = 0; n < 400 && p == 0; n++) begin
			cyc(1);
			if (outs[k] === 1'b1 && o === 1'b0) begin
				if (a >= 0) p = n - a;
				a = n;
			end
			o = outs[k];
		end
	endtask : per
	function automatic logic [31:0] pd(input logic [1:0] m);
		return m == 2'h0 ? 32'h0 : 32'h8 << m;
	endfunction : pd
	task automatic conclude;
		$display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : conclude
	// A hang counts as a mismatch.
	initial begin
		cyc(60000);
		miscompares++;
		conclude();
	end
	initial begin
		cyc(5);
		rst = 0;
		wr(15'h0050, 8'hFF);
		rdck(15'h0050, 8'h00);
		rdck(clock_output_pkg::bias_addr, 8'h4F);
		rdck(clock_output_pkg::emphasis_addr, 8'h00);
		rdck(clock_output_pkg::trigger_addr, 8'h00);
		rdck(clock_output_pkg::override_addr, 8'h00);
		// Reserved upper bits go back in as their default of zero.
		d = 8'($random(seed)) & 8'h0F;
		wr(clock_output_pkg::emphasis_addr, d);
		note({8{d[3:0]}}, lane_emphasis_level);
		rdck(clock_output_pkg::emphasis_addr, d);
		// The PLL configuration hold sits outside this block and is kept.
		wr(clock_output_pkg::bias_addr, 8'h4A);
		note(32'h4A, 32'(oscillator_bias_level));
		// Pin mode: register fields are present but must be ignored.
		wr(clock_output_pkg::override_addr, 8'h3F);
		repeat (4) begin
			{pll_enable_pin, ref_select_pin} = 2'($random(seed));
			cyc(1);
			note({pll_enable_pin, ref_select_pin},
				{pll_enable, single_ended_ref_select});
		end
		{clock_config_pin_b, clock_config_pin_a} = 2'h3;
		per(1);
		note(32'd64, p);
		per(2);
		note(32'd64, p);
		// Register mode: first and second modes run in opposite order.
		for (int i = 0; i < 4; i++) begin
			{pll_enable_pin, ref_select_pin} = ~{i[0], i[1]};
			wr(clock_output_pkg::override_addr,
				{2'h2, 2'(3 - i), 2'(i), i[1], i[0]});
			note({i[0], i[1]},
				{pll_enable, single_ended_ref_select});
			per(1);
			note(pd(2'(i)), p);
			per(2);
			note(i == 0 ? 0 : pd(2'(3 - i)), p);
		end
		// Select changes only while the trigger output is disabled.
		for (int s = 0; s < 8; s++) begin
			wr(clock_output_pkg::trigger_addr, 8'(s));
			wr(clock_output_pkg::trigger_addr, 8'(s) | 8'h80);
			repeat (s == 3 ? 4 : 0) begin
				timestamp_input = 1'($random(seed));
				cyc(1);
				note(timestamp_input, aux_output);
			end
			per(0);
			note(s < 3 ? 32 << s : 0, p);
			wr(clock_output_pkg::trigger_addr, 8'(s));
		end
		wr(clock_output_pkg::trigger_addr, 8'h00);
		per(0);
		note(0, p);
		wr(clock_output_pkg::trigger_addr, 8'h80);
		serializer_reinit = 1;
		per(0);
		note(0, p);
		serializer_reinit = 0;
		per(0);
		note(32, p);
		cyc(2);
		conclude();
	end
endmodule : test_clock_output_config_regs
